//--- bench/interleave_skew_config_test.sv
`timescale 1ns/1ps
module interleave_skew_config_test;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr_stb = 1'b0;
  logic [3:0] i_wr_addr = 4'h0;
  logic [15:0] i_wr_data = 16'h0;
  logic i_phase_late = 1'b0;
  logic i_phase_early = 1'b0;
  logic [1:0] o_mode;
  logic [21:0] o_clk_ctl;
  logic o_ofs_i_sign_step;
  logic o_ofs_q_sign_step;
  int err_count = 0;
  int samples_checked = 0;
  logic [8:0] fine;
  isc_interleave_skew_config i_isc_interleave_skew_config (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_wr_stb(i_wr_stb), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_phase_late(i_phase_late), .i_phase_early(i_phase_early), .o_mode(o_mode),
    .o_clk_ctl(o_clk_ctl), .o_ofs_i_sign_step(o_ofs_i_sign_step),
    .o_ofs_q_sign_step(o_ofs_q_sign_step));
  // Clock at 50 ns period
  initial forever #25 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_wr_stb = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
  endtask : wr
  task idle(input int n);
    @(negedge i_clk);
    i_wr_stb = 1'b0;
    repeat (n - 1) @(negedge i_clk);
  endtask : idle
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk({o_mode, o_clk_ctl}, 32'h0);
    wr(4'he, 16'h07ff);
    wr(4'hf, 16'h007f);
    wr(4'hd, 16'hbfff);
    idle(3);
    chk(o_mode, isc_pkg::ISC_INTERLEAVE_MANUAL);
    chk(o_clk_ctl, {4'h8, 18'h0});
    for (int k = 0; k < 8; k++)
    begin
      fine = (k == 7) ? 9'h1ff : 9'(k * 60);
      wr(4'he, {k[1], k[0], 3'(k), 11'h7ff});
      wr(4'hf, {fine, 7'h7f});
      idle(3);
      chk(o_clk_ctl, {2'h2, k[1], k[0], 18'(k * 20000 + fine * 100)});
    end
    $display("manual skew test done");
    wr(4'hd, 16'hffff);
    idle(3);
    chk(o_mode, isc_pkg::ISC_INTERLEAVE_AUTO);
    i_phase_late = 1'b1;
    idle(200);
    chk({o_clk_ctl[20], o_clk_ctl[18], o_clk_ctl[17:0]}, {2'h2, 18'd12700});
    i_phase_late = 1'b0;
    i_phase_early = 1'b1;
    idle(300);
    chk({o_clk_ctl[20], o_clk_ctl[18], o_clk_ctl[17:0]}, {2'h3, 18'd12700});
    i_phase_early = 1'b0;
    wr(4'hd, 16'h3fff);
    idle(3);
    chk({o_mode, o_clk_ctl[21:19], o_clk_ctl[17:0]}, 32'h0);
    $display("mode test done");
    wr(4'h2, 16'h00ff);
    wr(4'ha, 16'h007f);
    wr(4'h5, 16'h0000);
    idle(3);
    chk({o_ofs_i_sign_step, o_ofs_q_sign_step, o_mode}, 32'h8);
    wr(4'h2, 16'h007f);
    wr(4'ha, 16'h00ff);
    idle(3);
    chk({o_ofs_i_sign_step, o_ofs_q_sign_step}, 32'h1);
    wr(4'hd, 16'hffff);
    idle(3);
    i_rst_b = 1'b0;
    idle(2);
    chk({o_mode, o_clk_ctl, o_ofs_q_sign_step}, 32'h0);
    i_rst_b = 1'b1;
    idle(3);
    chk({o_mode, o_clk_ctl}, 32'h0);
    $display("offset and reset test done");
    tally_and_finish();
  end
endmodule : interleave_skew_config_test

//--- bench/isc_interleave_skew_config_properties.sv
`timescale 1ns/1ps
module isc_skew_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_stb,
  input wire logic [3:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [1:0] o_mode,
  input wire logic [21:0] o_clk_ctl,
  input wire logic o_ofs_i_sign_step,
  input wire logic o_ofs_q_sign_step
);
  logic wr_d;
  logic wr_2;
  logic wr_a;
  // ----------------------------------------------------------------
  // Write decode and step sequences
  // ----------------------------------------------------------------
  assign wr_d = i_wr_stb && (i_wr_addr == isc_pkg::ADDR_ENABLE);
  assign wr_2 = i_wr_stb && (i_wr_addr == isc_pkg::ADDR_OFFSET_I);
  assign wr_a = i_wr_stb && (i_wr_addr == isc_pkg::ADDR_OFFSET_Q);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_en_wr; wr_d ##1 !wr_d; endsequence
  sequence s_oi_wr; wr_2 ##1 !wr_2; endsequence
  sequence s_oq_wr; wr_a ##1 !wr_a; endsequence
  chk_interleave_follow: assert property (
    s_en_wr |-> ##1 o_clk_ctl[21] == $past(i_wr_data[15], 2))
    else $error("interleave flag does not follow write");
  chk_dual_mode: assert property (
    !o_clk_ctl[21] |-> o_mode == isc_pkg::ISC_DUAL)
    else $error("mode not dual with interleave off");
  chk_auto_flags: assert property (
    o_mode == isc_pkg::ISC_INTERLEAVE_AUTO |-> o_clk_ctl[21:20] == 2'h3)
    else $error("auto mode flags wrong");
  chk_dual_delay: assert property (
    o_mode == isc_pkg::ISC_DUAL |-> o_clk_ctl[17:0] == 18'h0 && !o_clk_ctl[20])
    else $error("delay present in dual mode");
  chk_route_gate: assert property (
    !o_clk_ctl[21] |-> !o_clk_ctl[19])
    else $error("q routing outside interleave");
  chk_ofs_i_sign: assert property (
    s_oi_wr |-> ##1 o_ofs_i_sign_step == $past(i_wr_data[7], 2))
    else $error("i offset sign mismatch");
  chk_ofs_q_sign: assert property (
    s_oq_wr |-> ##1 o_ofs_q_sign_step == $past(i_wr_data[7], 2))
    else $error("q offset sign mismatch");
  chk_reset_clear: assert property (
    $rose(i_rst_b) |-> o_mode == 2'h0 && o_clk_ctl == 22'h0)
    else $error("outputs not clear after reset");
endmodule : isc_skew_chk
bind isc_interleave_skew_config isc_skew_chk i_isc_skew_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_wr_stb(i_wr_stb), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .o_mode(o_mode),
  .o_clk_ctl(o_clk_ctl), .o_ofs_i_sign_step(o_ofs_i_sign_step),
  .o_ofs_q_sign_step(o_ofs_q_sign_step));

//--- logic/isc_interleave_skew_config.sv
`timescale 1ns/1ps
// Summary of operation
// - Enable bit at one runs both converters interleaved on one input at twice the clock.
// - Enable bit at zero runs the converters as two independent channels.
// - Auto phase bit at one, with the enable bit at one, turns on automatic phase control and ignores the manual skews.
// - In automatic mode a phase detector keeps the I and Q edges 180 degrees apart.
// - Auto phase bit at zero, with the enable bit at one, takes the I to Q delay from the coarse and fine fields.
// - Input select at one routes the Q input to both converters, in interleave only; with enable at zero the routing flag stays clear.
// - Direction zero delays the I clock, direction one delays the Q clock.
// - Each coarse code adds about 20 ps, and zero adds none.
// - Each fine code adds about 0.1 ps to the selected channel, and zero adds none.
// - Reset clears the control bits and both skew fields.
// - Plus zero and minus zero offsets differ by a small step in the output code.
module isc_interleave_skew_config #(
  parameter int PHASE_STEP_FS = 100,
  parameter int PHASE_ERR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_stb,
  input wire logic [isc_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [isc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_phase_late,
  input wire logic i_phase_early,
  output logic [1:0] o_mode,
  output logic [$bits(isc_pkg::isc_clk_ctl_type)-1:0] o_clk_ctl,
  output logic o_ofs_i_sign_step,
  output logic o_ofs_q_sign_step
);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Stored register words, one per mapped address
  logic [15:0] enable_reg_r;
  logic [15:0] coarse_reg_r;
  logic [15:0] fine_reg_r;
  logic [15:0] ofs_i_r;
  logic [15:0] ofs_q_r;
  // Address match of one register; shared by every write decode
  function automatic logic addr_hit(input logic stb,
                                    input logic [isc_pkg::ADDR_W-1:0] addr,
                                    input logic [isc_pkg::ADDR_W-1:0] target);
    addr_hit = stb && (addr == target);
  endfunction : addr_hit

  // Per-register strobes; an unmapped address matches none and is dropped
  wire wr_enable = addr_hit(i_wr_stb, i_wr_addr, isc_pkg::ADDR_ENABLE);
  wire wr_coarse = addr_hit(i_wr_stb, i_wr_addr, isc_pkg::ADDR_COARSE);
  wire wr_fine = addr_hit(i_wr_stb, i_wr_addr, isc_pkg::ADDR_FINE);
  wire wr_ofs_i = addr_hit(i_wr_stb, i_wr_addr, isc_pkg::ADDR_OFFSET_I);
  wire wr_ofs_q = addr_hit(i_wr_stb, i_wr_addr, isc_pkg::ADDR_OFFSET_Q);

  // Nothing reads these back, so the host must shadow what it wrote.
  // Unassigned bits are stored as written but feed no logic.
  // Each register has its own short process so a write touches one word.

  // Interleave enable register: enable and auto phase in the top two bits
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      enable_reg_r <= isc_pkg::RST_ENABLE;
    else if (wr_enable)
      enable_reg_r <= i_wr_data;
  end

  // Coarse skew register: input select, direction and coarse code
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      coarse_reg_r <= isc_pkg::RST_COARSE;
    else if (wr_coarse)
      coarse_reg_r <= i_wr_data;
  end

  // Fine skew register: fine code in the top nine bits
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fine_reg_r <= isc_pkg::RST_FINE;
    else if (wr_fine)
      fine_reg_r <= i_wr_data;
  end

  // I channel offset register; only its sign bit is used here
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ofs_i_r <= isc_pkg::RST_OFFSET;
    else if (wr_ofs_i)
      ofs_i_r <= i_wr_data;
  end

  // Q channel offset register; only its sign bit is used here
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ofs_q_r <= isc_pkg::RST_OFFSET;
    else if (wr_ofs_q)
      ofs_q_r <= i_wr_data;
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  // Enable register fields
  wire interleave_enable_bit = enable_reg_r[isc_pkg::ENABLE_BIT];
  wire auto_phase_control = enable_reg_r[isc_pkg::AUTO_BIT];

  // Coarse register fields
  wire input_select = coarse_reg_r[isc_pkg::INSEL_BIT];
  wire skew_direction_select = coarse_reg_r[isc_pkg::DIR_BIT];
  wire [2:0] coarse_magnitude = coarse_reg_r[isc_pkg::COARSE_HI:isc_pkg::COARSE_LO];

  // Fine register field
  wire [8:0] fine_magnitude = fine_reg_r[isc_pkg::FINE_HI:isc_pkg::FINE_LO];

  // Delay in fs for a coarse and fine code pair.
  // The largest pair fits the delay width, so the cut loses nothing.
  function automatic logic [isc_pkg::DELAY_W-1:0] skew_fs(input logic [2:0] c,
                                                          input logic [8:0] f);
    skew_fs = isc_pkg::DELAY_W'(c * isc_pkg::COARSE_STEP_FS + f * isc_pkg::FINE_STEP_FS);
  endfunction : skew_fs

  // Manual delay; zero codes give zero delay
  wire [isc_pkg::DELAY_W-1:0] manual_fs =
    skew_fs(coarse_magnitude, fine_magnitude);

  // ----------------------------------------------------------------
  // Automatic phase loop
  // ----------------------------------------------------------------
  // Tracks the detector: late pushes delay up, early pulls it down.
  // Detector inputs come from the analog core on another timebase.
  // Each step moves the delay by one phase step; the loop holds when idle.
  logic [2:0] late_sync_r;
  logic [2:0] early_sync_r;
  logic late_r;
  logic early_r;
  logic signed [PHASE_ERR_W-1:0] auto_trim_r;
  logic signed [PHASE_ERR_W-1:0] auto_trim_nxt;
  localparam logic signed [PHASE_ERR_W-1:0] TRIM_MAX = {1'b0, {(PHASE_ERR_W-1){1'b1}}};
  // Negative limit mirrors the positive one, so the magnitude never
  // needs the one code that has no positive partner
  localparam logic signed [PHASE_ERR_W-1:0] TRIM_MIN = -TRIM_MAX;

  // Detector levels are asynchronous here: three flops each, and a change
  // is taken only once the second and third stages agree, which also
  // drops a single-cycle glitch.

  // Late detector synchroniser
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      late_sync_r <= 3'h0;
      late_r <= 1'b0;
    end
    else
    begin
      late_sync_r <= {late_sync_r[1:0], i_phase_late};
      if (late_sync_r[1] == late_sync_r[2])
        late_r <= late_sync_r[2];
    end
  end

  // Early detector synchroniser
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      early_sync_r <= 3'h0;
      early_r <= 1'b0;
    end
    else
    begin
      early_sync_r <= {early_sync_r[1:0], i_phase_early};
      if (early_sync_r[1] == early_sync_r[2])
        early_r <= early_sync_r[2];
    end
  end

  // Saturating trim, held at zero outside automatic interleave.
  // Both detector levels high at once is treated as no error and holds.
  // Clearing on exit means a later entry starts from the centre again,
  // instead of from a stale correction left by an earlier run.
  wire auto_run = interleave_enable_bit && auto_phase_control;
  always_comb
  begin
    auto_trim_nxt = auto_trim_r;
    if (!auto_run)
      auto_trim_nxt = '0;
    else if (late_r && !early_r && auto_trim_r != TRIM_MAX)
      auto_trim_nxt = auto_trim_r + 1'b1;
    else if (early_r && !late_r && auto_trim_r != TRIM_MIN)
      auto_trim_nxt = auto_trim_r - 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      auto_trim_r <= '0;
    else
      auto_trim_r <= auto_trim_nxt;
  end

  // Magnitude and side of the automatic correction.
  // A positive trim delays the I clock, a negative one the Q clock.
  wire auto_on_q = auto_trim_r[PHASE_ERR_W-1];
  wire [PHASE_ERR_W-1:0] auto_mag = auto_on_q ? PHASE_ERR_W'(-auto_trim_r) : auto_trim_r;
  wire [isc_pkg::DELAY_W-1:0] auto_fs =
    isc_pkg::DELAY_W'(auto_mag * PHASE_STEP_FS);

  // ----------------------------------------------------------------
  // Mode and clock control selection
  // ----------------------------------------------------------------
  // Enable off wins over auto phase: dual mode ignores both skew registers.
  // In interleave the auto bit then picks detector or manual delay,
  // so a stale manual setting never leaks into automatic operation.
  isc_pkg::isc_mode_type mode_nxt;
  isc_pkg::isc_clk_ctl_type ctl_nxt;
  assign mode_nxt = !interleave_enable_bit ? isc_pkg::ISC_DUAL :
                    auto_phase_control ? isc_pkg::ISC_INTERLEAVE_AUTO :
                    isc_pkg::ISC_INTERLEAVE_MANUAL;

  always_comb
  begin
    ctl_nxt.interleave = interleave_enable_bit;
    ctl_nxt.auto_phase = auto_run;
    ctl_nxt.route_q_both = interleave_enable_bit && input_select;
    ctl_nxt.delay_on_q = 1'b0;
    ctl_nxt.delay_fs = '0;
    case (mode_nxt)
      isc_pkg::ISC_INTERLEAVE_MANUAL:
      begin
        ctl_nxt.delay_on_q = skew_direction_select;
        ctl_nxt.delay_fs = manual_fs;
      end
      isc_pkg::ISC_INTERLEAVE_AUTO:
      begin
        ctl_nxt.delay_on_q = auto_on_q;
        ctl_nxt.delay_fs = auto_fs;
      end
      isc_pkg::ISC_DUAL:
      begin
        ctl_nxt.delay_on_q = 1'b0;
        ctl_nxt.delay_fs = '0;
      end
      default:
      begin
        ctl_nxt.delay_on_q = 1'b0;
        ctl_nxt.delay_fs = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Offset sign step flags
  // ----------------------------------------------------------------
  // A set sign bit shifts the code by a fraction of an LSB even at zero magnitude.
  // The flag lets the core tell plus zero from minus zero, so software
  // cannot treat a zero offset with either sign as the same setting.
  wire ofs_i_step = ofs_i_r[isc_pkg::OFS_SIGN_BIT];
  wire ofs_q_step = ofs_q_r[isc_pkg::OFS_SIGN_BIT];

  // Registered outputs; every top-level output leaves a flop

  // Operating mode
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_mode <= 2'h0;
    else
      o_mode <= mode_nxt;
  end

  // Sample-clock control word
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_clk_ctl <= '0;
    else
      o_clk_ctl <= ctl_nxt;
  end

  // I offset sign step
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_ofs_i_sign_step <= 1'b0;
    else
      o_ofs_i_sign_step <= ofs_i_step;
  end

  // Q offset sign step
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_ofs_q_sign_step <= 1'b0;
    else
      o_ofs_q_sign_step <= ofs_q_step;
  end

endmodule : isc_interleave_skew_config

//--- logic/isc_pkg.sv
package isc_pkg;

  // ----------------------------------------------------------------
  // Register addresses and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_ENABLE = 4'hd;
  localparam logic [3:0] ADDR_COARSE = 4'he;
  localparam logic [3:0] ADDR_FINE = 4'hf;
  localparam logic [3:0] ADDR_OFFSET_I = 4'h2;
  localparam logic [3:0] ADDR_OFFSET_Q = 4'ha;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 15;
  localparam int AUTO_BIT = 14;
  localparam int INSEL_BIT = 15;
  localparam int DIR_BIT = 14;
  localparam int COARSE_HI = 13;
  localparam int COARSE_LO = 11;
  localparam int FINE_HI = 15;
  localparam int FINE_LO = 7;
  localparam int OFS_SIGN_BIT = 7;
  localparam int OFS_HI = 15;
  localparam int OFS_LO = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ENABLE = 16'h3fff;
  localparam logic [15:0] RST_COARSE = 16'h07ff;
  localparam logic [15:0] RST_FINE = 16'h007f;
  localparam logic [15:0] RST_OFFSET = 16'h007f;

  // ----------------------------------------------------------------
  // Delay step sizes in femtoseconds
  // ----------------------------------------------------------------
  localparam int COARSE_STEP_FS = 20000;
  localparam int FINE_STEP_FS = 100;
  localparam int DELAY_W = 18;

  // Operating mode of the converter pair
  typedef enum logic [1:0] {
    ISC_DUAL,
    ISC_INTERLEAVE_MANUAL,
    ISC_INTERLEAVE_AUTO
  } isc_mode_type;

  // Sample-clock control bundle toward the analog core
  typedef struct packed {
    logic interleave;
    logic auto_phase;
    logic route_q_both;
    logic delay_on_q;
    logic [DELAY_W-1:0] delay_fs;
  } isc_clk_ctl_type;

endpackage : isc_pkg
